/* File: sim/ancm_nv_model.sv */
// ancm_nv_model.sv - nonvolatile store model for the notch 3/4 frequencies
// assumes save strobes and reset on the core clock
`timescale 1ns/1ns
module ancm_nv_model #(
  parameter logic [12:0] INIT3 = 13'h03E8,
  parameter logic [12:0] INIT4 = 13'h07D0
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        save_i,
  input  wire logic [12:0] save3_i,
  input  wire logic [12:0] save4_i,
  output logic             load_valid_o,
  output logic [12:0]      freq3_o,
  output logic [12:0]      freq4_o
);
  logic [12:0] mem3 = INIT3;
  logic [12:0] mem4 = INIT4;
  logic [3:0]  dly;
  // count cycles after power-up, one load strobe
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) dly <= 4'h0;
    else if (dly != 4'hF) dly <= dly + 4'h1;
  end
  // keep the last snapshot across resets
  always @(posedge clk_i) begin
    if (save_i) begin
      mem3 <= save3_i;
      mem4 <= save4_i;
    end
  end
  // data lines show garbage outside the strobe
  assign load_valid_o = (dly == 4'h3);
  assign freq3_o      = load_valid_o ? mem3 : ~mem3;
  assign freq4_o      = load_valid_o ? mem4 : ~mem4;
endmodule

/* File: sim/ancm_top_tb.sv */
// ancm_top_tb.sv - self-checking bench of the adaptive notch control
// assumes ancm_top with a short save period and the nv store model
`timescale 1ns/1ns
module ancm_top_tb;
  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [5:0]       adr = 6'h00;
  logic             rd = 1'b0;
  logic             wr = 1'b0;
  logic [31:0]      wdat = 32'h0;
  logic             force_ctrl = 1'b0;
  logic             vld = 1'b0;
  logic [12:0]      f0 = 13'h0000;
  logic [12:0]      f1 = 13'h0000;
  logic [31:0]      rdat, q, e0;
  logic             wreq, nv_vld, sv, arst;
  logic [12:0]      nv3, nv4, s3, s4, h3, h4;
  logic [3:0][12:0] nf;
  logic [3:0][6:0]  nd;
  logic [3:0]       ne;
  int               failures = 0;
  int               n_compared = 0;

  ancm_top #(.SAVE_CYCLES(50)) ancm_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .force_ctrl_i(force_ctrl),
    .vib_valid_i(vld), .vib_freq0_i(f0), .vib_freq1_i(f1), .nv_load_valid_i(nv_vld),
    .nv_freq3_i(nv3), .nv_freq4_i(nv4), .nv_save_o(sv), .nv_save3_o(s3),
    .nv_save4_o(s4), .notch_freq_o(nf), .notch_depth_o(nd), .notch_en_o(ne),
    .adapt_rst_o(arst));
  ancm_nv_model ancm_nv_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .save_i(sv),
    .save3_i(s3), .save4_i(s4), .load_valid_o(nv_vld), .freq3_o(nv3), .freq4_o(nv4));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  task check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task conclude;
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task nap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    check(n < 20, "bus hang");
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task vib(input int n, input logic [12:0] a, input logic [12:0] b);
    repeat (n) begin
      @(posedge clk_i);
      vld <= 1'b1;
      f0 <= a;
      f1 <= b;
      @(posedge clk_i);
      vld <= 1'b0;
    end
    nap(4);
  endtask
  function logic near(input logic [12:0] v, input logic [12:0] t);
    return (v + 13'h0008 >= t) && (v <= t + 13'h0008);
  endfunction
  task lim(input logic [12:0] f, input logic [6:0] d, input logic e);
    bus(1'b1, 6'h10, {19'h0, f});
    bus(1'b1, 6'h20, {25'h0, d});
    nap(3);
    check(ne[0] === e && nd[0] === d, "notch1 enable");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_restore;
    check(nf[2] === 13'h03E8 && nf[3] === 13'h07D0, "restore");
    bus(1'b0, 6'h18, 32'h0);
    check(q[12:0] === 13'h03E8, "notch3 read");
    bus(1'b0, 6'h3C, 32'h0);
    check(q === 32'h0, "unmapped read");
  endtask
  task t_limits;
    lim(13'h0031, 7'h00, 1'b0);
    lim(13'h0032, 7'h00, 1'b1);
    lim(13'h1387, 7'h63, 1'b1);
    lim(13'h1388, 7'h00, 1'b0);
    lim(13'h0032, 7'h64, 1'b0);
    bus(1'b1, 6'h20, 32'h65);
    bus(1'b0, 6'h20, 32'h0);
    check(q[6:0] === 7'h64, "depth clamp");
    bus(1'b1, 6'h20, 32'h0);
    bus(1'b1, 6'h24, 32'h64);
    nap(3);
    check(nd[1] === 7'h64 && ne[1] === 1'b0, "notch2 depth off");
  endtask
  task t_adapt(input logic [2:0] s, input logic [12:0] a, input logic [12:0] b);
    bus(1'b1, 6'h04, 32'h0);
    bus(1'b1, 6'h00, {29'h0, s});
    h4 = nf[3];
    vib(30, a, b);
    check(near(nf[2], a), "notch3 adapt");
    check(s == 3'h1 ? nf[3] === h4 : near(nf[3], b), "notch4 adapt");
    check(nf[0] === 13'h0032 && nf[1] === 13'h1388, "low notches");
  endtask
  task t_meas;
    h3 = nf[2];
    h4 = nf[3];
    bus(1'b1, 6'h00, 32'h3);
    vib(30, 13'h0320, 13'h0384);
    check(nf[2] === h3 && nf[3] === h4, "measure applied");
    bus(1'b0, 6'h30, 32'h0);
    check(near(q[12:0], 13'h0320), "measure estimate");
  endtask
  task t_force;
    bus(1'b1, 6'h00, 32'h1);
    h3 = nf[2];
    bus(1'b0, 6'h30, 32'h0);
    e0 = q;
    @(posedge clk_i) force_ctrl <= 1'b1;
    vib(30, 13'h02BC, 13'h02BC);
    bus(1'b0, 6'h30, 32'h0);
    check(q === e0 && ne[2] === 1'b0, "force hold");
    for (int m = 5; m <= 6; m++) begin
      bus(1'b1, 6'h04, 32'(m));
      nap(3);
      check(ne[2] === 1'b1 && nf[2] === h3, "force mode keep");
    end
    @(posedge clk_i) force_ctrl <= 1'b0;
    bus(1'b1, 6'h04, 32'h0);
  endtask
  task t_clear;
    bus(1'b1, 6'h00, 32'h4);
    nap(3);
    check(nf[2] === 13'h1388 && nf[3] === 13'h1388, "clear freq");
    check(ne[3:2] === 2'b00 && arst === 1'b1, "clear off");
    bus(1'b0, 6'h0C, 32'h0);
    check(q[2:1] === 2'b00 && q[0] === 1'b1, "clear estimate");
    bus(1'b1, 6'h18, 32'h3E8);
    bus(1'b0, 6'h18, 32'h0);
    check(q[12:0] === 13'h1388, "clear blocks write");
  endtask
  task t_recover;
    bus(1'b1, 6'h00, 32'h0);
    nap(2);
    check(arst === 1'b1, "off resets adaption");
    bus(1'b1, 6'h18, 32'h1388);
    bus(1'b1, 6'h1C, 32'h1388);
    bus(1'b1, 6'h00, 32'h1);
    nap(2);
    check(arst === 1'b0 && ne[3:2] === 2'b00, "recover");
    check(nf[2] === 13'h1388 && nf[3] === 13'h1388, "recover freq");
    bus(1'b1, 6'h08, 32'h2);
    bus(1'b1, 6'h00, 32'h7);
    bus(1'b0, 6'h08, 32'h0);
    check(q[3:0] === 4'h2, "rigidity lowered");
    bus(1'b0, 6'h00, 32'h0);
    check(q[2:0] === 3'h1, "bad select ignored");
  endtask
  task t_save;
    int n;
    bus(1'b1, 6'h18, 32'h258);
    bus(1'b1, 6'h1C, 32'h320);
    nap(3);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sv !== 1'b1 && n < 80);
    check(sv === 1'b1 && s3 === 13'h0258 && s4 === 13'h0320, "periodic save");
    @(posedge clk_i) sys_rst_i <= 1'b1;
    nap(5);
    sys_rst_i <= 1'b0;
    nap(10);
    check(nf[2] === 13'h0258 && nf[3] === 13'h0320, "power cycle");
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    nap(5);
    sys_rst_i <= 1'b0;
    nap(10);
    t_restore;
    t_limits;
    t_adapt(3'h1, 13'h04B0, 13'h0BB8);
    t_adapt(3'h2, 13'h05DC, 13'h09C4);
    t_meas;
    t_force;
    t_clear;
    t_recover;
    t_save;
    conclude;
  end
  initial begin
    #500000;
    failures++;
    conclude;
  end
endmodule

/* File: verilog/ancm_bus_slave.sv */
// ancm_bus_slave.sv - avalon-mm slave with one wait cycle per access
// assumes the master holds its request until waitrequest is low
`timescale 1ns/1ns
module ancm_bus_slave (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  ancm_reg_if.slave        rif
);
  // waitrequest drops for one cycle per request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !((read_i || write_i) && waitrequest_o);
    end
  end
  // read data captured while waiting
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && waitrequest_o) begin
      readdata_o <= rif.rdata;
    end
  end
  // write takes effect at the accepting edge
  assign rif.wr_en = write_i && !waitrequest_o;
  assign rif.addr  = address_i;
  assign rif.wdata = writedata_i;
endmodule

/* File: verilog/ancm_cfg.svh */
// ancm_cfg.svh - register map, reset values and limits of the adaptive notch control
// assumes a 32-bit word bus with byte addresses
`ifndef ANCM_CFG_SVH
`define ANCM_CFG_SVH
`define ANCM_OFS_SEL   6'h00
`define ANCM_OFS_CMODE 6'h04
`define ANCM_OFS_RIGID 6'h08
`define ANCM_OFS_STAT  6'h0C
`define ANCM_OFS_FREQ  6'h10
`define ANCM_OFS_DEPTH 6'h20
`define ANCM_OFS_EST0  6'h30
`define ANCM_OFS_EST1  6'h34
`define ANCM_FREQ_MIN  13'h0032
`define ANCM_FREQ_MAX  13'h1387
`define ANCM_FREQ_OFF  13'h1388
`define ANCM_DEPTH_OFF 7'h64
`define ANCM_DEPTH_RST 7'h00
`define ANCM_CMODE_F5  4'h5
`define ANCM_CMODE_F6  4'h6
`define ANCM_SAVE_MIN  30
`define ANCM_CONV_CNT  4'h8
`endif

/* File: verilog/ancm_freq_est.sv */
// ancm_freq_est.sv - smooths resonance candidates into one notch frequency
// assumes candidates arrive as single-cycle strobes on the core clock
`timescale 1ns/1ns
`include "ancm_cfg.svh"
module ancm_freq_est (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               clr_i,
  input  wire logic               hold_i,
  input  wire logic               load_i,
  input  wire ancm_pkg::ancm_freq_t load_val_i,
  input  wire logic               cand_valid_i,
  input  wire ancm_pkg::ancm_freq_t cand_i,
  output ancm_pkg::ancm_freq_t    est_o,
  output logic                    valid_o,
  output logic                    upd_o
);
  logic [3:0]  cnt_reg;
  logic [13:0] diff;
  // one quarter step toward each candidate
  assign diff = {1'b0, cand_i} - {1'b0, est_o};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      est_o   <= `ANCM_FREQ_OFF;
      cnt_reg <= 4'h0;
      valid_o <= 1'b0;
      upd_o   <= 1'b0;
    end else begin
      upd_o <= 1'b0;
      // stored start value wins over a clear that stands at power-up
      if (load_i) begin
        est_o <= load_val_i;
      end else if (clr_i) begin
        est_o   <= `ANCM_FREQ_OFF;
        cnt_reg <= 4'h0;
        valid_o <= 1'b0;
      end else if (cand_valid_i && !hold_i) begin
        est_o <= est_o + 13'({{2{diff[13]}}, diff[13:2]});
        if (cnt_reg == `ANCM_CONV_CNT) begin
          valid_o <= 1'b1;
          upd_o   <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

/* File: verilog/ancm_pkg.sv */
// ancm_pkg.sv - types of the adaptive notch control
// assumes nothing beyond the config header
package ancm_pkg;
  typedef enum logic [2:0] {
    ANCM_SEL_OFF, ANCM_SEL_ONE, ANCM_SEL_TWO, ANCM_SEL_MEAS, ANCM_SEL_CLEAR
  } ancm_sel_e;
  typedef enum logic {ANCM_ST_RESTORE, ANCM_ST_RUN} ancm_state_e;
  typedef logic [12:0] ancm_freq_t;
endpackage

/* File: verilog/ancm_reg_if.sv */
// ancm_reg_if.sv - register access carrier between bus slave and core
// assumes one clock domain
`timescale 1ns/1ns
interface ancm_reg_if;
  logic        wr_en;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr_en, addr, wdata, input rdata);
  modport core  (input wr_en, addr, wdata, output rdata);
endinterface

/* File: verilog/ancm_top.sv */
// ancm_top.sv - adaptive notch control: selection, apply, hold, save, restore
// assumes vibration candidates, force flag and nonvolatile port on clk_i
`timescale 1ns/1ns
`include "ancm_cfg.svh"

//----------------------------------------------------------------------
// Function
// - estimate resonance from speed vibration and set notch frequency automatically
// - automatic frequencies go only to third or fourth notch
// - select 0 off, 1 one estimate, 2 two estimates each own notch
// - select 3 measures resonance but applies it to no notch
// - select 4 disables third and fourth notch and clears estimates
// - select 0 also resets mass estimation and adaptive state
// - 5000 Hz in third or fourth notch means that notch is off
// - third and fourth frequencies saved to nonvolatile memory every 30 min
// - saved frequencies restored after power-up as adaptive start values
// - adaptation suspended while force control is active
// - control mode 5 or 6 keeps the previous adaptive frequency
// - four notch filters in series on the force command
// - notch active only for frequency 50 to 4999 Hz
// - depth 100 disables notch, otherwise depth 0 to 99
//----------------------------------------------------------------------
module ancm_top #(
  parameter int unsigned     CLK_NS      = 10,
  parameter longint unsigned SAVE_CYCLES =
    longint'(`ANCM_SAVE_MIN) * 64'd60_000_000_000 / longint'(CLK_NS)
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        force_ctrl_i,
  input  wire logic        vib_valid_i,
  input  wire logic [12:0] vib_freq0_i,
  input  wire logic [12:0] vib_freq1_i,
  input  wire logic        nv_load_valid_i,
  input  wire logic [12:0] nv_freq3_i,
  input  wire logic [12:0] nv_freq4_i,
  output logic             nv_save_o,
  output logic [12:0]      nv_save3_o,
  output logic [12:0]      nv_save4_o,
  output logic [3:0][12:0] notch_freq_o,
  output logic [3:0][6:0]  notch_depth_o,
  output logic [3:0]       notch_en_o,
  output logic             adapt_rst_o
);
  // refuse a save interval the 38-bit timer cannot count
  if (SAVE_CYCLES < 2 || SAVE_CYCLES > 64'h3F_FFFF_FFFF || CLK_NS == 0) begin : g_bad_cfg
    $error("ancm_top: save interval out of range");
  end

  //--------------------------------------------------------------------
  // state and registers
  //--------------------------------------------------------------------
  ancm_reg_if rif ();
  ancm_pkg::ancm_sel_e     sel_reg;
  ancm_pkg::ancm_state_e   state_reg;
  logic [3:0]              cmode_reg;
  logic [3:0]              rigid_reg;
  logic [3:0][12:0]        freq_reg;
  logic [3:0][6:0]         depth_reg;
  logic [37:0]             save_cnt_reg;
  logic [1:0][12:0]        est;
  logic [1:0]              est_valid;
  logic [1:0]              est_upd;
  logic [3:0]              freq_hit;
  logic [3:0]              depth_hit;
  logic [3:0]              adapt_upd;
  logic [3:0]              en_next;
  logic                    est_clr;
  logic                    mode56;
  logic                    restore_load;
  logic                    save_due;

  //--------------------------------------------------------------------
  // bus slave
  //--------------------------------------------------------------------
  ancm_bus_slave u_slave (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .address_i     (avs_address_i),
    .read_i        (avs_read_i),
    .write_i       (avs_write_i),
    .writedata_i   (avs_writedata_i),
    .readdata_o    (avs_readdata_o),
    .waitrequest_o (avs_waitrequest_o),
    .rif           (rif)
  );

  //--------------------------------------------------------------------
  // decode and control terms
  //--------------------------------------------------------------------
  // adaptive state cleared by select 0 or 4
  assign est_clr      = (sel_reg == ancm_pkg::ANCM_SEL_OFF) ||
                        (sel_reg == ancm_pkg::ANCM_SEL_CLEAR);
  assign mode56       = (cmode_reg == `ANCM_CMODE_F5) || (cmode_reg == `ANCM_CMODE_F6);
  assign restore_load = (state_reg == ancm_pkg::ANCM_ST_RESTORE) && nv_load_valid_i;
  assign save_due     = (save_cnt_reg == 38'(SAVE_CYCLES - 64'd1));

  // per notch hits and automatic updates
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_notch
      assign freq_hit[gi]  = rif.wr_en && (rif.addr == `ANCM_OFS_FREQ + 6'(4 * gi));
      assign depth_hit[gi] = rif.wr_en && (rif.addr == `ANCM_OFS_DEPTH + 6'(4 * gi));
      if (gi < 2) begin : g_manual
        assign adapt_upd[gi] = 1'b0;
      end else begin : g_auto
        assign adapt_upd[gi] = est_upd[gi-2] && !force_ctrl_i &&
          ((sel_reg == ancm_pkg::ANCM_SEL_TWO) ||
           (gi == 2 && sel_reg == ancm_pkg::ANCM_SEL_ONE));
      end
      // active only in range, with depth below 100
      assign en_next[gi] = (freq_reg[gi] >= `ANCM_FREQ_MIN) &&
                           (freq_reg[gi] <= `ANCM_FREQ_MAX) &&
                           (depth_reg[gi] != `ANCM_DEPTH_OFF) &&
                           !(gi >= 2 && force_ctrl_i && !mode56 &&
                             (sel_reg == ancm_pkg::ANCM_SEL_ONE ||
                              sel_reg == ancm_pkg::ANCM_SEL_TWO));
      // notch frequency register
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          freq_reg[gi] <= `ANCM_FREQ_OFF;
        end else if (gi >= 2 && restore_load) begin
          freq_reg[gi] <= (gi == 2) ? nv_freq3_i : nv_freq4_i;
        end else if (gi >= 2 && sel_reg == ancm_pkg::ANCM_SEL_CLEAR) begin
          freq_reg[gi] <= `ANCM_FREQ_OFF;
        end else if (freq_hit[gi]) begin
          freq_reg[gi] <= rif.wdata[12:0];
        end else if (adapt_upd[gi]) begin
          // modulo keeps the index legal in the manual slots as well
          freq_reg[gi] <= est[gi % 2];
        end
      end
      // notch depth register, values above 100 clipped to off
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          depth_reg[gi] <= `ANCM_DEPTH_RST;
        end else if (depth_hit[gi]) begin
          depth_reg[gi] <= (rif.wdata[6:0] > `ANCM_DEPTH_OFF) ? `ANCM_DEPTH_OFF :
                           rif.wdata[6:0];
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------
  // estimators, one per adaptive notch
  //--------------------------------------------------------------------
  ancm_freq_est u_est0 (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .clr_i        (est_clr),
    .hold_i       (force_ctrl_i),
    .load_i       (restore_load),
    .load_val_i   (nv_freq3_i),
    .cand_valid_i (vib_valid_i),
    .cand_i       (vib_freq0_i),
    .est_o        (est[0]),
    .valid_o      (est_valid[0]),
    .upd_o        (est_upd[0])
  );
  ancm_freq_est u_est1 (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .clr_i        (est_clr),
    .hold_i       (force_ctrl_i),
    .load_i       (restore_load),
    .load_val_i   (nv_freq4_i),
    .cand_valid_i (vib_valid_i),
    .cand_i       (vib_freq1_i),
    .est_o        (est[1]),
    .valid_o      (est_valid[1]),
    .upd_o        (est_upd[1])
  );

  //--------------------------------------------------------------------
  // software registers
  //--------------------------------------------------------------------
  // adaptive selection, unknown codes ignored
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_reg <= ancm_pkg::ANCM_SEL_OFF;
    end else if (rif.wr_en && rif.addr == `ANCM_OFS_SEL &&
                 rif.wdata[2:0] <= 3'h4) begin
      sel_reg <= ancm_pkg::ancm_sel_e'(rif.wdata[2:0]);
    end
  end
  // control mode and rigidity selection
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmode_reg <= 4'h0;
      rigid_reg <= 4'h0;
    end else if (rif.wr_en && rif.addr == `ANCM_OFS_CMODE) begin
      cmode_reg <= rif.wdata[3:0];
    end else if (rif.wr_en && rif.addr == `ANCM_OFS_RIGID) begin
      rigid_reg <= rif.wdata[3:0];
    end
  end

  // read decode, unmapped reads as zero
  always_comb begin
    rif.rdata = 32'h0000_0000;
    if (rif.addr == `ANCM_OFS_SEL) begin
      rif.rdata = {29'h0, sel_reg};
    end else if (rif.addr == `ANCM_OFS_CMODE) begin
      rif.rdata = {28'h0, cmode_reg};
    end else if (rif.addr == `ANCM_OFS_RIGID) begin
      rif.rdata = {28'h0, rigid_reg};
    end else if (rif.addr == `ANCM_OFS_STAT) begin
      rif.rdata = {25'h0, notch_en_o, est_valid,
                   state_reg == ancm_pkg::ANCM_ST_RUN};
    end else if (rif.addr[5:4] == 2'h1) begin
      rif.rdata = {19'h0, freq_reg[rif.addr[3:2]]};
    end else if (rif.addr[5:4] == 2'h2) begin
      rif.rdata = {25'h0, depth_reg[rif.addr[3:2]]};
    end else if (rif.addr == `ANCM_OFS_EST0) begin
      rif.rdata = {19'h0, est[0]};
    end else if (rif.addr == `ANCM_OFS_EST1) begin
      rif.rdata = {19'h0, est[1]};
    end
  end

  //--------------------------------------------------------------------
  // restore and periodic save
  //--------------------------------------------------------------------
  // wait for stored frequencies after power-up
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ancm_pkg::ANCM_ST_RESTORE;
    end else begin
      case (state_reg)
        ancm_pkg::ANCM_ST_RESTORE: begin
          if (nv_load_valid_i) begin
            state_reg <= ancm_pkg::ANCM_ST_RUN;
          end
        end
        default: begin
          state_reg <= ancm_pkg::ANCM_ST_RUN;
        end
      endcase
    end
  end
  // save timer and snapshot
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      save_cnt_reg <= 38'h0;
      nv_save_o    <= 1'b0;
      nv_save3_o   <= `ANCM_FREQ_OFF;
      nv_save4_o   <= `ANCM_FREQ_OFF;
    end else begin
      nv_save_o <= 1'b0;
      if (save_due) begin
        save_cnt_reg <= 38'h0;
        nv_save_o    <= 1'b1;
        nv_save3_o   <= freq_reg[2];
        nv_save4_o   <= freq_reg[3];
      end else begin
        save_cnt_reg <= save_cnt_reg + 38'h1;
      end
    end
  end

  //--------------------------------------------------------------------
  // filter outputs
  //--------------------------------------------------------------------
  // four notches handed to the series filter chain
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      notch_freq_o  <= {4{`ANCM_FREQ_OFF}};
      notch_depth_o <= {4{`ANCM_DEPTH_RST}};
      notch_en_o    <= 4'h0;
      adapt_rst_o   <= 1'b1;
    end else begin
      notch_freq_o  <= freq_reg;
      notch_depth_o <= depth_reg;
      notch_en_o    <= en_next;
      adapt_rst_o   <= est_clr;
    end
  end

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_apply_one: assert property (
    adapt_upd[2] && !freq_hit[2] && state_reg == ancm_pkg::ANCM_ST_RUN &&
    sel_reg == ancm_pkg::ANCM_SEL_ONE |=> freq_reg[2] == $past(est[0]) ##1
    notch_freq_o[2] == $past(est[0], 2))
    else $error("estimate not applied to third notch");
  chk_first_fixed: assert property (
    !freq_hit[0] && !freq_hit[1] |=> $stable(freq_reg[0]) && $stable(freq_reg[1]))
    else $error("first or second notch changed without a write");
  chk_one_only: assert property (
    sel_reg == ancm_pkg::ANCM_SEL_ONE |-> !adapt_upd[3])
    else $error("fourth notch updated in single mode");
  chk_meas_only: assert property (
    sel_reg == ancm_pkg::ANCM_SEL_MEAS |-> adapt_upd == 4'h0)
    else $error("measurement mode applied a result");
  chk_clear_off: assert property (
    (sel_reg == ancm_pkg::ANCM_SEL_CLEAR && !restore_load) [*2] |->
    freq_reg[2] == `ANCM_FREQ_OFF && freq_reg[3] == `ANCM_FREQ_OFF && est_valid == 2'h0)
    else $error("clear mode left notch or estimate");
  chk_off_reset: assert property (
    sel_reg == ancm_pkg::ANCM_SEL_OFF [*2] |-> est_valid == 2'h0 ##1 adapt_rst_o)
    else $error("disable did not reset adaptive state");
  chk_en_range: assert property (
    1'b1 |=> notch_en_o[0] == ($past(freq_reg[0]) >= `ANCM_FREQ_MIN &&
      $past(freq_reg[0]) <= `ANCM_FREQ_MAX && $past(depth_reg[0]) != `ANCM_DEPTH_OFF))
    else $error("first notch enable disagrees with range");
  chk_off_value: assert property (
    freq_reg[2] == `ANCM_FREQ_OFF |=> !notch_en_o[2])
    else $error("5000 Hz notch still enabled");
  chk_depth_off: assert property (
    depth_reg[1] == `ANCM_DEPTH_OFF |=> !notch_en_o[1])
    else $error("depth 100 notch still enabled");
  chk_force_hold: assert property (
    force_ctrl_i |-> adapt_upd == 4'h0)
    else $error("adaptation ran under force control");
  chk_mode_keep: assert property (
    force_ctrl_i && mode56 && !freq_hit[2] && !restore_load &&
    sel_reg == ancm_pkg::ANCM_SEL_ONE |=> $stable(freq_reg[2]))
    else $error("held frequency changed in mode 5 or 6");
  chk_save_tick: assert property (
    nv_save_o |-> $past(save_cnt_reg) == 38'(SAVE_CYCLES - 64'd1) &&
    nv_save3_o == $past(freq_reg[2]) && save_cnt_reg == 38'h0)
    else $error("save pulse off schedule");
  chk_restore: assert property (
    restore_load |=> freq_reg[3] == $past(nv_freq4_i) &&
    state_reg == ancm_pkg::ANCM_ST_RUN && est[0] == $past(nv_freq3_i))
    else $error("restore did not load stored values");

  cov_two_notch: cover property (adapt_upd[2] && adapt_upd[3]);
  cov_force_hold: cover property (force_ctrl_i && mode56 && est_valid[0]);
  cov_save: cover property (nv_save_o);
  cov_clear: cover property (sel_reg == ancm_pkg::ANCM_SEL_CLEAR ##1
                             sel_reg == ancm_pkg::ANCM_SEL_ONE);
endmodule
